// *** bench/spb_monitor.sv ***
// spb_monitor: port-level checks of the serial port, bound into the design.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module spb_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic clk_pin_in,
  input wire logic data_pin_in,
  input wire spb_pkg::spb_pins_s pins,
  input wire logic rx_ready,
  input wire logic tx_ready,
  input wire logic wake_pulse
);
  logic en_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // shadow of port enable, rebuilt from register writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_q <= 1'b0;
    end else if (reg_wr && reg_addr == spb_pkg::OFF_RX_CTRL) begin
      en_q <= reg_wdata[spb_pkg::PORT_ENABLE];
    end
  end
  pins_off_a: assert property (!en_q && !$past(en_q) && !$past(en_q, 2)
    |-> !pins.clk_pin_oe && !pins.data_pin_oe) else $error("pin driven while off");
  tx_gate_a: assert property (!en_q |-> !tx_ready) else $error("tx ready while off");
  wake_once_a: assert property (wake_pulse |=> !wake_pulse) else $error("long wake");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray data");
  rd_unmapped_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h7
    |-> reg_rdata == 8'h00) else $error("unmapped read data");
  shift_empty_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h0
    && !$past(en_q) && !$past(en_q, 2) |-> reg_rdata[1]) else $error("shift empty low");
  rx_idle_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h2
    && !$past(en_q) && !$past(en_q, 2) |-> reg_rdata[6]) else $error("rx idle low");
  rx_clear_a: assert property (reg_rd && reg_addr == 3'h6 |-> ##2 !rx_ready)
    else $error("rx ready kept after read");
endmodule
`default_nettype wire

// *** bench/spb_peer_model.sv ***
// spb_peer_model: remote serial peer exchanging async frames.
// assumes 8-bit frames, normal polarity, bit time given in system clocks.
`timescale 1ns/1ps
`default_nettype none
module spb_peer_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_sys,
  input wire logic tx_line,
  output logic rx_line
);
  logic [7:0] got_q[$];
  logic [7:0] b;
  initial rx_line = 1'b1;
  // frame sender: start, data lsb first, stop; line left high as idle
  task automatic send(input logic [7:0] d);
    for (int i = -1; i < 9; i++) begin
      @(posedge clk_sys);
      rx_line <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : d[i];
      repeat (BIT_CLKS - 1) @(posedge clk_sys);
    end
  endtask
  // frame catcher: mid-bit samples; a bad stop bit corrupts the byte on purpose
  always begin
    wait (tx_line === 1'b1);
    @(negedge tx_line);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_sys);
      b[i] = tx_line;
    end
    repeat (BIT_CLKS) @(posedge clk_sys);
    got_q.push_back((tx_line === 1'b1) ? b : ~b);
  end
endmodule
`default_nettype wire

// *** bench/spb_serial_port_tb_top.sv ***
// spb_serial_port_tb_top: self-checking bench for the serial port.
// assumes the peer model on the pins and a 20 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module spb_serial_port_tb_top;
  localparam int BIT_CLKS = 32; // high speed, divisor 1: 16 ticks of 2 clocks
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic data_pin_in, rx_ready, tx_ready, wake_pulse;
  spb_pkg::spb_pins_s pins;
  int error_cnt = 0;
  int checks = 0;
  int wake_n = 0;
  logic [7:0] exp_q[$];
  logic [7:0] b;
  spb_serial_port dut_u (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .clk_pin_in(1'b0), .data_pin_in, .pins, .rx_ready, .tx_ready, .wake_pulse);
  spb_peer_model #(.BIT_CLKS(BIT_CLKS)) peer_u (.clk_sys, .tx_line(pins.clk_pin_out),
    .rx_line(data_pin_in));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // counts wake pulses seen at the port
  always @(posedge clk_sys) begin
    if (wake_pulse === 1'b1) wake_n++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // bounded wait for a received byte or a caught frame
  task automatic wait_for(input bit want_rx);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_sys);
      #1;
      if (want_rx ? rx_ready === 1'b1 : peer_u.got_q.size() > 0) break;
    end
    if (n == 2000) begin
      error_cnt++;
      close_out();
    end
  endtask
  initial begin
    void'($urandom(43));
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    rd(3'h0, 8'h02);
    rd(3'h2, 8'h40);
    rd(3'h1, 8'h00);
    rd(3'h7, 8'h00);
    b = 8'($urandom()) & 8'h38;
    wr(3'h2, b);
    rd(3'h2, b | 8'h40);
    // async link: high speed, divisor 1, transmitter, port and receiver on
    wr(3'h2, 8'h00);
    wr(3'h4, 8'h01); // never program a zero divisor
    wr(3'h0, 8'h24);
    wr(3'h1, 8'h90);
    for (int k = 0; k < 3; k++) begin
      b = 8'($urandom());
      exp_q.push_back(b);
      wr(3'h5, b);
      wait_for(1'b0);
      check(peer_u.got_q.pop_front(), exp_q.pop_front());
      repeat (BIT_CLKS) @(posedge clk_sys);
      rd(3'h0, 8'h26);
      b = 8'($urandom());
      exp_q.push_back(b);
      peer_u.send(b);
      wait_for(1'b1);
      rd(3'h6, exp_q.pop_front());
      rd(3'h1, 8'h90);
    end
    // break: 12 low bit times, so the peer sees all zeros and a low stop bit
    wr(3'h0, 8'h2C);
    wr(3'h5, 8'($urandom()));
    wait_for(1'b0);
    check(peer_u.got_q.pop_front(), 8'hFF);
    repeat (4 * BIT_CLKS) @(posedge clk_sys);
    rd(3'h0, 8'h26);
    // wake-up: one pulse on the fall, enable dropped on the following rise
    wr(3'h2, 8'h02);
    peer_u.send(8'hFF);
    check(wake_n[7:0], 8'h01);
    rd(3'h2, 8'h40);
    close_out();
  end
endmodule
bind spb_serial_port spb_monitor mon_u (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .clk_pin_in, .data_pin_in, .pins, .rx_ready, .tx_ready, .wake_pulse);
`default_nettype wire

// *** src/spb_pkg.sv ***
// spb_pkg: register map, field positions, reset values and types of the serial port.
// assumes a byte-wide register port and a single system clock.
package spb_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] OFF_TX_CTRL = 3'h0;
  localparam logic [2:0] OFF_RX_CTRL = 3'h1;
  localparam logic [2:0] OFF_BAUD_CTRL = 3'h2;
  localparam logic [2:0] OFF_DIV_HIGH = 3'h3;
  localparam logic [2:0] OFF_DIV_LOW = 3'h4;
  localparam logic [2:0] OFF_TX_DATA = 3'h5;
  localparam logic [2:0] OFF_RX_DATA = 3'h6;
  // transmit_status_control fields
  localparam int CLOCK_SOURCE_SELECT = 7;
  localparam int NINE_BIT_TRANSMIT = 6;
  localparam int TRANSMIT_ENABLE = 5;
  localparam int MODE_SELECT = 4;
  localparam int SEND_BREAK = 3;
  localparam int HIGH_SPEED_SELECT = 2;
  localparam int NINTH_TRANSMIT_BIT = 0;
  // receive_status_control fields
  localparam int PORT_ENABLE = 7;
  localparam int NINE_BIT_RECEIVE = 6;
  localparam int SINGLE_RECEIVE_ENABLE = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int ADDRESS_DETECT_ENABLE = 3;
  // baud_rate_control fields
  localparam int RECEIVE_POLARITY_SELECT = 5;
  localparam int TRANSMIT_CLOCK_POLARITY_SELECT = 4;
  localparam int WIDE_BAUD_SELECT = 3;
  localparam int WAKEUP_ENABLE = 1;
  localparam int AUTOBAUD_ENABLE = 0;
  // writable masks and reset values of the stored control bits
  localparam logic [7:0] TX_CTRL_WMASK = 8'hFD;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h3B;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  // timing counts in baud timer ticks and oversample ticks
  localparam logic [1:0] LOW_SPEED_PRESCALE_LAST = 2'h3; // 64 = 4 x 16
  localparam logic [3:0] OVS_LAST = 4'hF;                // 16 samples per bit
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_DECIDE = 4'h9;
  localparam logic [1:0] SYNC_LEAD_PHASE = 2'h0;         // 4 ticks per clocked bit
  localparam logic [1:0] SYNC_TRAIL_PHASE = 2'h2;
  localparam logic [3:0] BREAK_BITS = 4'hD;              // start plus 11 low, then stop
  localparam logic [9:0] ABD_PRESCALE_SLOW = 10'h1FF;    // 8 bits x 64 clocks
  localparam logic [9:0] ABD_PRESCALE_FAST = 10'h07F;    // 8 bits x 16 clocks
  localparam logic [2:0] ABD_LAST_EDGE = 3'h5;           // 55h gives five falling edges

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_SYNC} spb_rx_state_e;

  // pad-facing signals; serial_clock pin doubles as async transmit line
  typedef struct packed {
    logic clk_pin_out;
    logic clk_pin_oe;
    logic data_pin_out;
    logic data_pin_oe;
  } spb_pins_s;
endpackage

// *** src/spb_serial_port.sv ***
// spb_serial_port: control, baud timer and serial engines of a universal serial port.
// assumes pads resolve the pin enables; pin inputs are asynchronous to clk_sys.
// Notes on behaviour
// RL1 - port enable off holds baud timer, engines and buffers in reset and releases both pins
// RL2 - clocked mode: clock source select picks master clock or external slave clock
// RL3 - nine-bit selects per direction; ninth transmit bit comes from control register
// RL4 - mode select chooses clocked half-duplex or asynchronous full-duplex operation
// RL5 - send break makes next async frame a 12-bit break; cleared when sent
// RL6 - transmit shift empty reads one when shifter idle; resets to one
// RL7 - clocked mode: any receive enable overrides transmit enable
// RL8 - single receive takes one character in clocked master, then clears itself
// RL9 - continuous receive enables async receiver and overrides single receive when clocked
// RL10 - nine-bit address detect accepts only characters whose ninth bit is one
// RL11 - framing error flag refreshed when the next valid character is loaded
// RL12 - overrun sets error flag; cleared by clearing continuous receive
// RL13 - ninth received bit only captured; parity is software's job
// RL14 - timer rollover during auto-baud sets sticky flag, software clears it
// RL15 - receive idle status reads one when no reception active; resets to one
// RL16 - polarity bits invert async receive data, transmit idle level, or clock idle
// RL17 - wide baud select uses both divisor bytes, otherwise low byte only
// RL18 - wake-up: falling receive edge gives pulse, next rising edge clears enable
// RL19 - auto-baud measures next 55h character, loads divisor, then clears enable
// RL20 - divisor sets free-running timer period; high speed ignored when clocked
// RL21 - any divisor write clears the baud timer at once
// RL22 - divisor of zero unsupported; software must never program it
// RL23 - rate is clock over 64, 16 or 4 times divisor plus one
// RL24 - async receive majority of three samples unless high speed and wide
// RL25 - async frame: start bit, 8 or 9 data bits lsb first, stop bit
`timescale 1ns/1ps
`default_nettype none
module spb_serial_port (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic clk_pin_in,
  input wire logic data_pin_in,
  output spb_pkg::spb_pins_s pins,
  output logic rx_ready,
  output logic tx_ready,
  output logic wake_pulse
);
  logic [7:0] txc, rxc, bdc, div_hi, div_lo, tx_buf, rx_buf;
  logic autobaud_rollover_flag, framing_error_flag, overrun_error_flag, ninth_receive_bit, tx_full, rx_full;
  logic rx_m, rx_s, ck_m, ck_s, rx_prev, ck_prev;
  logic [15:0] brg_cnt;
  logic [1:0] pre_cnt, ph;
  logic ck_act;
  spb_pkg::spb_rx_state_e rx_st;
  logic [3:0] rx_os, rx_bit;
  logic [8:0] rx_sh;
  logic [1:0] maj;
  logic rx_done, rx_fe;
  logic tx_busy, tx_brk, tx_line;
  logic [12:0] tx_sh;
  logic [3:0] tx_left, tx_os;
  logic abd_run, abd_done, abd_ovf_ev;
  logic [2:0] abd_edges;
  logic [9:0] abd_pre;
  logic [15:0] abd_cnt;
  logic wk_armed;

  // control bit aliases
  wire port_enable = rxc[spb_pkg::PORT_ENABLE];
  wire port_rst = srst | ~port_enable; // [RL1]
  wire sync_mode = txc[spb_pkg::MODE_SELECT];
  wire clock_source_select = txc[spb_pkg::CLOCK_SOURCE_SELECT];
  wire tx9 = txc[spb_pkg::NINE_BIT_TRANSMIT];
  wire transmit_enable = txc[spb_pkg::TRANSMIT_ENABLE];
  wire send_break = txc[spb_pkg::SEND_BREAK];
  wire high_speed_select = txc[spb_pkg::HIGH_SPEED_SELECT];
  wire ninth_transmit_bit = txc[spb_pkg::NINTH_TRANSMIT_BIT];
  wire rx9 = rxc[spb_pkg::NINE_BIT_RECEIVE];
  wire single_receive_enable = rxc[spb_pkg::SINGLE_RECEIVE_ENABLE];
  wire continuous_receive_enable = rxc[spb_pkg::CONTINUOUS_RECEIVE_ENABLE];
  wire address_detect_enable = rxc[spb_pkg::ADDRESS_DETECT_ENABLE];
  wire receive_polarity_select = bdc[spb_pkg::RECEIVE_POLARITY_SELECT];
  wire transmit_clock_polarity_select = bdc[spb_pkg::TRANSMIT_CLOCK_POLARITY_SELECT];
  wire wide_baud_select = bdc[spb_pkg::WIDE_BAUD_SELECT];
  wire wakeup_enable = bdc[spb_pkg::WAKEUP_ENABLE];
  wire autobaud_enable = bdc[spb_pkg::AUTOBAUD_ENABLE];

  wire wr_div = reg_wr & (reg_addr == spb_pkg::OFF_DIV_HIGH || reg_addr == spb_pkg::OFF_DIV_LOW);
  wire rd_rxd = reg_rd & (reg_addr == spb_pkg::OFF_RX_DATA);
  wire wr_txd = reg_wr & (reg_addr == spb_pkg::OFF_TX_DATA);

  // mode decode: receive request wins the half-duplex line
  wire sync_rx = sync_mode & (continuous_receive_enable | (single_receive_enable & clock_source_select)); // [RL7] [RL8] [RL9]
  wire tx_allowed = transmit_enable & ~(sync_mode & (continuous_receive_enable | single_receive_enable)); // [RL7]
  wire master = sync_mode & clock_source_select; // [RL2]
  wire async_rx_en = ~sync_mode & continuous_receive_enable & ~overrun_error_flag & ~autobaud_enable & ~wakeup_enable; // [RL9] [RL4]

  // two-flop synchronisers on both pins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      ck_m <= 1'b0;
      ck_s <= 1'b0;
    end else begin
      rx_m <= data_pin_in;
      rx_s <= rx_m;
      ck_m <= clk_pin_in;
      ck_s <= ck_m;
    end
  end

  wire rx_lvl = rx_s ^ (receive_polarity_select & ~sync_mode); // [RL16]
  wire ck_lvl = ck_s ^ transmit_clock_polarity_select; // [RL16] slave clock, active high after polarity
  wire rx_fall = rx_prev & ~rx_lvl;
  wire rx_rise = ~rx_prev & rx_lvl;

  // edge history for receive line and slave clock
  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      rx_prev <= 1'b1;
      ck_prev <= 1'b0;
    end else begin
      rx_prev <= rx_lvl;
      ck_prev <= ck_lvl;
    end
  end

  // free-running baud timer; period is divisor plus one clocks
  wire [15:0] div_val = wide_baud_select ? {div_hi, div_lo} : {8'h00, div_lo}; // [RL17]
  wire brg_tick = (brg_cnt >= div_val);
  always_ff @(posedge clk_sys) begin
    if (port_rst || wr_div || abd_done) begin
      brg_cnt <= 16'h0000; // [RL21]
    end else if (brg_tick) begin
      brg_cnt <= 16'h0000; // [RL20]
    end else begin
      brg_cnt <= brg_cnt + 16'h0001;
    end
  end

  // low-speed 8-bit async needs 64 timer ticks per bit, i.e. 4 ticks per sample
  wire fast = sync_mode | high_speed_select | wide_baud_select; // [RL20] high speed ignored when clocked
  wire os_tick = brg_tick & (fast | pre_cnt == spb_pkg::LOW_SPEED_PRESCALE_LAST); // [RL23]
  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      pre_cnt <= 2'h0;
    end else if (brg_tick) begin
      pre_cnt <= pre_cnt + 2'h1;
    end
  end

  // clocked-mode edges: master from 4-tick phase counter, slave from the pin
  wire master_run = master & (sync_rx | tx_busy);
  wire lead_ev = master ? (master_run & brg_tick & ph == spb_pkg::SYNC_LEAD_PHASE)
                        : (sync_mode & ck_lvl & ~ck_prev);
  wire trail_ev = master ? (master_run & brg_tick & ph == spb_pkg::SYNC_TRAIL_PHASE)
                         : (sync_mode & ~ck_lvl & ck_prev);
  always_ff @(posedge clk_sys) begin
    if (port_rst || !master_run) begin
      ph <= 2'h0;
      ck_act <= 1'b0;
    end else begin
      if (brg_tick) begin
        ph <= ph + 2'h1; // [RL23] clocked bit is 4 timer periods
      end
      if (lead_ev) begin
        ck_act <= 1'b1;
      end else if (trail_ev) begin
        ck_act <= 1'b0;
      end
    end
  end

  // bit decision at the third sample: majority or single sample
  wire single_smp = high_speed_select & wide_baud_select; // [RL24]
  wire maj3 = (maj[1] & maj[0]) | (maj[1] & rx_lvl) | (maj[0] & rx_lvl);
  wire bitv = single_smp ? maj[0] : maj3; // [RL24]
  wire [3:0] rx_last = rx9 ? 4'h8 : 4'h7; // [RL3]
  wire decide = os_tick & (rx_os == spb_pkg::SAMPLE_DECIDE);
  wire os_end = os_tick & (rx_os == spb_pkg::OVS_LAST);

  // receive engine, async and clocked
  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      rx_st <= spb_pkg::RX_IDLE;
      rx_os <= 4'h0;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
      maj <= 2'h0;
      rx_done <= 1'b0;
      rx_fe <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (os_tick) begin
        rx_os <= rx_os + 4'h1;
        if (rx_os >= spb_pkg::SAMPLE_FIRST && rx_os < spb_pkg::SAMPLE_DECIDE) begin
          maj <= {maj[0], rx_lvl};
        end
      end
      case (rx_st)
        spb_pkg::RX_IDLE: begin
          if (sync_rx) begin
            rx_st <= spb_pkg::RX_SYNC;
            rx_bit <= 4'h0;
          end else if (async_rx_en && rx_fall) begin
            rx_st <= spb_pkg::RX_START;
            rx_os <= 4'h0;
          end
        end
        spb_pkg::RX_START: begin
          if (!async_rx_en || (decide && bitv)) begin
            rx_st <= spb_pkg::RX_IDLE; // false start or receiver off
          end else if (os_end) begin
            rx_st <= spb_pkg::RX_DATA;
            rx_bit <= 4'h0;
          end
        end
        spb_pkg::RX_DATA: begin
          if (!async_rx_en) begin
            rx_st <= spb_pkg::RX_IDLE;
          end else begin
            if (decide) begin
              rx_sh <= {bitv, rx_sh[8:1]}; // [RL25] lsb first
            end
            if (os_end) begin
              rx_bit <= rx_bit + 4'h1;
              if (rx_bit == rx_last) begin
                rx_st <= spb_pkg::RX_STOP;
              end
            end
          end
        end
        spb_pkg::RX_STOP: begin
          if (!async_rx_en) begin
            rx_st <= spb_pkg::RX_IDLE;
          end else if (decide) begin
            rx_done <= 1'b1;
            rx_fe <= ~bitv; // [RL25] stop bit must be high
            rx_st <= spb_pkg::RX_IDLE; // leave mid-stop so next start is seen
          end
        end
        spb_pkg::RX_SYNC: begin
          if (!sync_rx) begin
            rx_st <= spb_pkg::RX_IDLE;
          end else if (trail_ev) begin
            rx_sh <= {rx_lvl, rx_sh[8:1]};
            rx_fe <= 1'b0;
            if (rx_bit == rx_last) begin
              rx_done <= 1'b1;
              rx_bit <= 4'h0;
            end else begin
              rx_bit <= rx_bit + 4'h1;
            end
          end
        end
        default: rx_st <= spb_pkg::RX_IDLE;
      endcase
    end
  end

  // receive buffer, error flags; a load beats a same-cycle read clear
  wire [7:0] rx_word = rx9 ? rx_sh[7:0] : rx_sh[8:1];
  wire rx_b8 = rx9 & rx_sh[8]; // [RL13] captured only, no parity check
  wire rx_accept = ~(~sync_mode & rx9 & address_detect_enable & ~rx_b8); // [RL10]
  wire full_eff = rx_full & ~rd_rxd;
  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      ninth_receive_bit <= 1'b0;
    end else begin
      if (rx_done && rx_accept && !full_eff) begin
        rx_buf <= rx_word;
        ninth_receive_bit <= rx_b8;
        framing_error_flag <= rx_fe; // [RL11]
        rx_full <= 1'b1;
      end else if (rd_rxd) begin
        rx_full <= 1'b0;
      end
      if (rx_done && rx_accept && full_eff) begin
        overrun_error_flag <= 1'b1; // [RL12] character lost, async receiver stalls
      end else if (!continuous_receive_enable) begin
        overrun_error_flag <= 1'b0; // [RL12]
      end
    end
  end

  // transmit holding buffer
  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
    end else if (wr_txd) begin
      tx_buf <= reg_wdata;
      tx_full <= 1'b1;
    end else if (!tx_busy && tx_full && tx_allowed) begin
      tx_full <= 1'b0;
    end
  end

  // transmit shifter: async frames or break on oversample ticks, clocked on edges
  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      tx_busy <= 1'b0;
      tx_brk <= 1'b0;
      tx_line <= 1'b1;
      tx_sh <= 13'h1FFF;
      tx_left <= 4'h0;
      tx_os <= 4'h0;
    end else if (!tx_busy) begin
      tx_line <= 1'b1;
      if (tx_full && tx_allowed) begin
        tx_busy <= 1'b1;
        tx_os <= 4'h0;
        if (sync_mode) begin
          tx_sh <= {4'hF, ninth_transmit_bit, tx_buf};
          tx_left <= tx9 ? 4'h9 : 4'h8; // [RL3]
          tx_brk <= 1'b0;
        end else if (send_break) begin
          tx_line <= 1'b0;
          tx_sh <= 13'h1FFF; // only the stop level remains after the low bits
          tx_left <= spb_pkg::BREAK_BITS - 4'h1; // [RL5]
          tx_brk <= 1'b1;
        end else begin
          tx_line <= 1'b0; // [RL25] start bit
          tx_sh <= {4'hF, tx9 ? ninth_transmit_bit : 1'b1, tx_buf}; // [RL3]
          tx_left <= tx9 ? 4'hA : 4'h9;
          tx_brk <= 1'b0;
        end
      end
    end else if (sync_mode) begin
      if (lead_ev && tx_left != 4'h0) begin
        tx_line <= tx_sh[0];
        tx_sh <= {1'b1, tx_sh[12:1]};
        tx_left <= tx_left - 4'h1;
      end else if (trail_ev && tx_left == 4'h0) begin
        tx_busy <= 1'b0;
      end
    end else if (os_tick) begin
      tx_os <= tx_os + 4'h1;
      if (tx_os == spb_pkg::OVS_LAST) begin
        if (tx_left == 4'h0) begin
          tx_busy <= 1'b0;
        end else begin
          tx_line <= tx_brk && tx_left > 4'h1 ? 1'b0 : tx_sh[0];
          tx_sh <= {1'b1, tx_sh[12:1]};
          tx_left <= tx_left - 4'h1;
        end
      end
    end
  end
  wire brk_sent = tx_busy & tx_brk & os_tick & tx_os == spb_pkg::OVS_LAST & tx_left == 4'h0;

  // auto-baud: count clock/(8 x multiplier) across the 8 bit times of 55h
  wire abd_mode = autobaud_enable & ~sync_mode; // [RL19]
  wire [9:0] abd_pre_last = fast ? spb_pkg::ABD_PRESCALE_FAST : spb_pkg::ABD_PRESCALE_SLOW;
  assign abd_done = abd_run & rx_fall & (abd_edges == spb_pkg::ABD_LAST_EDGE - 3'h1);
  assign abd_ovf_ev = abd_run & (abd_pre == abd_pre_last) & (abd_cnt == 16'hFFFF); // [RL14]
  always_ff @(posedge clk_sys) begin
    if (port_rst || !abd_mode) begin
      abd_run <= 1'b0;
      abd_edges <= 3'h0;
      abd_pre <= 10'h000;
      abd_cnt <= 16'h0000;
    end else if (!abd_run) begin
      if (rx_fall && abd_edges == 3'h0) begin
        abd_run <= 1'b1; // start bit opens the measurement
        abd_edges <= 3'h1;
      end
    end else begin
      if (rx_fall) begin
        abd_edges <= abd_edges + 3'h1;
      end
      if (abd_done) begin
        abd_run <= 1'b0;
        abd_edges <= 3'h0;
      end
      if (abd_pre == abd_pre_last) begin
        abd_pre <= 10'h000;
        abd_cnt <= abd_cnt + 16'h0001; // rolls over; flag records it
      end else begin
        abd_pre <= abd_pre + 10'h001;
      end
    end
  end
  wire [15:0] abd_div = (abd_cnt == 16'h0000) ? 16'h0000 : abd_cnt - 16'h0001;

  // wake-up watch: pulse on falling edge, disarm on the following rising edge
  wire wk_mode = wakeup_enable & ~sync_mode & port_enable;
  wire wk_clear = wk_mode & wk_armed & rx_rise; // [RL18]
  always_ff @(posedge clk_sys) begin
    if (port_rst || !wk_mode) begin
      wk_armed <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= rx_fall & ~wk_armed; // [RL18]
      if (rx_fall) begin
        wk_armed <= 1'b1;
      end
    end
  end

  // control registers: software writes, hardware self-clears
  wire single_receive_enable_done = rx_done & sync_mode & clock_source_select & ~continuous_receive_enable; // [RL8]
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      txc <= spb_pkg::CTRL_RST;
      rxc <= spb_pkg::CTRL_RST;
      bdc <= spb_pkg::CTRL_RST;
    end else begin
      if (reg_wr && reg_addr == spb_pkg::OFF_TX_CTRL) begin
        txc <= reg_wdata & spb_pkg::TX_CTRL_WMASK;
      end else if (brk_sent) begin
        txc[spb_pkg::SEND_BREAK] <= 1'b0; // [RL5]
      end
      if (reg_wr && reg_addr == spb_pkg::OFF_RX_CTRL) begin
        rxc <= reg_wdata & spb_pkg::RX_CTRL_WMASK;
      end else if (single_receive_enable_done) begin
        rxc[spb_pkg::SINGLE_RECEIVE_ENABLE] <= 1'b0; // [RL8]
      end
      if (reg_wr && reg_addr == spb_pkg::OFF_BAUD_CTRL) begin
        bdc <= reg_wdata & spb_pkg::BAUD_CTRL_WMASK;
      end else begin
        if (wk_clear) begin
          bdc[spb_pkg::WAKEUP_ENABLE] <= 1'b0; // [RL18]
        end
        if (abd_done) begin
          bdc[spb_pkg::AUTOBAUD_ENABLE] <= 1'b0; // [RL19]
        end
      end
    end
  end

  // rollover flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      autobaud_rollover_flag <= 1'b0;
    end else if (abd_ovf_ev) begin
      autobaud_rollover_flag <= 1'b1; // [RL14]
    end else if (reg_wr && reg_addr == spb_pkg::OFF_BAUD_CTRL) begin
      autobaud_rollover_flag <= reg_wdata[7];
    end
  end

  // divisor pair: software write or auto-baud result
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_hi <= spb_pkg::DIV_RST;
      div_lo <= spb_pkg::DIV_RST;
    end else if (abd_done) begin
      div_hi <= abd_div[15:8]; // [RL19]
      div_lo <= abd_div[7:0];
    end else if (reg_wr && reg_addr == spb_pkg::OFF_DIV_HIGH) begin
      div_hi <= reg_wdata;
    end else if (reg_wr && reg_addr == spb_pkg::OFF_DIV_LOW) begin
      div_lo <= reg_wdata;
    end
  end

  // status views
  wire transmit_shift_empty = ~tx_busy; // [RL6]
  wire receive_idle_status = (rx_st == spb_pkg::RX_IDLE) & ~abd_run; // [RL15]

  // read port: data valid in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == spb_pkg::OFF_TX_CTRL) begin
        reg_rdata <= {txc[7:2], transmit_shift_empty, txc[0]};
      end else if (reg_addr == spb_pkg::OFF_RX_CTRL) begin
        reg_rdata <= {rxc[7:3], framing_error_flag, overrun_error_flag, ninth_receive_bit};
      end else if (reg_addr == spb_pkg::OFF_BAUD_CTRL) begin
        reg_rdata <= {autobaud_rollover_flag, receive_idle_status, bdc[5:3], 1'b0, bdc[1:0]};
      end else if (reg_addr == spb_pkg::OFF_DIV_HIGH) begin
        reg_rdata <= div_hi;
      end else if (reg_addr == spb_pkg::OFF_DIV_LOW) begin
        reg_rdata <= div_lo;
      end else if (reg_addr == spb_pkg::OFF_RX_DATA) begin
        reg_rdata <= rx_buf;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // pin drive, registered; disabled port floats both pins
  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      pins <= '0; // [RL1]
    end else if (!sync_mode) begin
      pins.clk_pin_out <= tx_line ^ transmit_clock_polarity_select; // [RL16] idle level follows polarity
      pins.clk_pin_oe <= 1'b1;
      pins.data_pin_out <= 1'b0;
      pins.data_pin_oe <= 1'b0;
    end else begin
      pins.clk_pin_out <= ck_act ^ transmit_clock_polarity_select; // [RL16] [RL2]
      pins.clk_pin_oe <= master;
      pins.data_pin_out <= tx_line;
      pins.data_pin_oe <= tx_busy; // [RL4] half-duplex
    end
  end

  assign rx_ready = rx_full;
  assign tx_ready = port_enable & transmit_enable & ~tx_full;
endmodule
`default_nettype wire
